// >>> inc/efd_pkg.sv
package efd_pkg;
  localparam int NUM_TAGS = 16;
  localparam int CTR_W = 7;
  localparam logic [6:0] CTR_MAX = 7'h7F;
  localparam logic [6:0] CTR_ZERO = 7'h00;
  // mode packet layout
  localparam logic [7:0] PKT_ID = 8'h03;
  localparam int PKT_ID_MSB = 31;
  localparam int PKT_ID_LSB = 24;
  localparam int PKT_FRAG_DEC_BIT = 23;
  localparam int PKT_FORCE_BIT = 22;
  localparam int PKT_TAG_MSB = 15;
  // register byte offsets
  localparam logic [7:0] OFS_MODE_PKT = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TAG_EN = 8'h08;
  localparam logic [7:0] OFS_TAG_CTR = 8'h40;
  localparam logic [7:0] OFS_TAG_CTR_END = 8'h7C;
  // status register fields
  localparam int ST_MODE_BIT = 0;
  localparam int ST_FORCE_BIT = 1;
  localparam int ST_FRAG_LSB = 8;
  // values after reset
  localparam logic [15:0] RST_TAG_DEC = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h00000000;
endpackage

// >>> inc/sat_ctr_if.sv
interface sat_ctr_if;
  logic inc;
  logic dec;
  logic clear;
  logic [6:0] value;
  modport counter (input inc, input dec, input clear, output value);
  modport ctrl (output inc, output dec, output clear, input value);
endinterface

// >>> hw/sat_counter.sv
module sat_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  sat_ctr_if.counter bus
);
  typedef struct packed {
    logic [6:0] count;
  } ctr_state_t;

  ctr_state_t state_reg;
  ctr_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (bus.clear) begin
      state_next.count = efd_pkg::CTR_ZERO;
    end else if (bus.inc && !bus.dec) begin
      if (state_reg.count != efd_pkg::CTR_MAX) begin
        state_next.count = state_reg.count + 7'h01;
      end
    end else if (bus.dec && !bus.inc) begin
      if (state_reg.count != efd_pkg::CTR_ZERO) begin
        state_next.count = state_reg.count - 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign bus.value = state_reg.count;

  ////////////////////////////////////////////////////////////////////////////
  sat_high_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !bus.clear && bus.inc && !bus.dec && bus.value == 7'h7F)
      |=> bus.value == 7'h7F)
    else $error("counter wrapped above its top");
  sat_low_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !bus.clear && bus.dec && !bus.inc && bus.value == 7'h00)
      |=> bus.value == 7'h00)
    else $error("counter wrapped below zero");
  inc_step_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !bus.clear && bus.inc && !bus.dec && bus.value != 7'h7F)
      |=> bus.value == $past(bus.value) + 7'h01)
    else $error("increment did not add one");
  dec_step_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !bus.clear && bus.dec && !bus.inc && bus.value != 7'h00)
      |=> bus.value == $past(bus.value) - 7'h01)
    else $error("decrement did not take one");
  ctr_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!clk_en || (!bus.clear && bus.inc == bus.dec)) |=> $stable(bus.value))
    else $error("counter moved without cause");
  ctr_clear_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && bus.clear) |=> bus.value == 7'h00)
    else $error("counter not cleared");
endmodule

// >>> hw/every_frame_decode_control.sv
// Notes on behaviour
// - in every-frame mode each frame is decoded, programmed or not.
// - in every-frame mode a frame-end status report goes out each frame.
// - host force bit puts the device into every-frame mode regardless.
// - one fragment counter plus sixteen tag enable counters.
// - tag assignment vector bumps the matching tag counter.
// - fragmentable message vector bumps the fragment counter.
// - mode stays on until all counters are zero and force is clear.
// - with force clear, mode follows only the counters.
// - only vectors increment, only host mode packets decrement.
// - counters saturate at 127 and at 0.
// - counters clear on reset and when the decoder is off.
// - fragment-decrement bit lowers the fragment counter by one.
// - each set tag-decrement bit lowers its tag counter by one.
// - a tag is disabled once its counter reaches zero.
// - mode packet: id 03, byte 2 bits 7 and 6, bytes 1-0 tag bits.
// - held decrement and force bits read zero after reset.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
module every_frame_decode_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic decoder_on,
  input wire logic tag_assign_valid,
  input wire logic [3:0] tag_assign_index,
  input wire logic frag_vector_valid,
  input wire logic frame_start,
  input wire logic programmed_frame,
  input wire logic frame_end,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic every_frame_decode_mode,
  output logic decode_frame,
  output logic status_valid,
  output logic status_eof,
  output logic [15:0] tag_enabled
);
  typedef struct packed {
    logic busy;
    logic [31:0] rdata;
    logic frag_count_decrement;
    logic forced_wide_decode;
    logic [15:0] tag_count_decrement;
    logic mode;
    logic decode;
    logic stat_valid;
    logic stat_eof;
    logic [15:0] tag_en;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // counters: index 0..15 tags, index 16 fragments
  sat_ctr_if ctr_bus [efd_pkg::NUM_TAGS+1] ();
  logic [6:0] ctr_val [efd_pkg::NUM_TAGS+1];
  logic pkt_accept;
  logic pkt_ok;
  logic any_busy;

  assign pkt_ok = avs_writedata[efd_pkg::PKT_ID_MSB:efd_pkg::PKT_ID_LSB] == efd_pkg::PKT_ID
    && avs_byteenable == 4'hF;
  assign pkt_accept = avs_write && !state_reg.busy
    && avs_address == efd_pkg::OFS_MODE_PKT && pkt_ok;

  genvar gi;
  generate
    for (gi = 0; gi < efd_pkg::NUM_TAGS; gi++) begin : g_tag
      assign ctr_bus[gi].inc = tag_assign_valid && tag_assign_index == 4'(gi);
      assign ctr_bus[gi].dec = pkt_accept && avs_writedata[gi];
      assign ctr_bus[gi].clear = !decoder_on;
    end
    for (gi = 0; gi <= efd_pkg::NUM_TAGS; gi++) begin : g_ctr
      assign ctr_val[gi] = ctr_bus[gi].value;
      sat_counter u_ctr (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .bus(ctr_bus[gi])
      );
    end
  endgenerate

  assign ctr_bus[efd_pkg::NUM_TAGS].inc = frag_vector_valid;
  assign ctr_bus[efd_pkg::NUM_TAGS].dec = pkt_accept
    && avs_writedata[efd_pkg::PKT_FRAG_DEC_BIT];
  assign ctr_bus[efd_pkg::NUM_TAGS].clear = !decoder_on;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [15:0] en_now;
    logic [3:0] idx;
    en_now = '0;
    idx = '0;
    any_busy = 1'b0;
    for (int i = 0; i < efd_pkg::NUM_TAGS; i++) begin
      en_now[i] = ctr_val[i] != efd_pkg::CTR_ZERO;
    end
    any_busy = (|en_now) || ctr_val[efd_pkg::NUM_TAGS] != efd_pkg::CTR_ZERO;
    state_next = state_reg;
    state_next.tag_en = en_now;
    state_next.mode = state_reg.forced_wide_decode || any_busy;
    state_next.decode = frame_start && (programmed_frame || state_reg.mode);
    state_next.stat_valid = frame_end && state_reg.mode;
    state_next.stat_eof = frame_end && state_reg.mode;
    // bus slave: one wait cycle, then a one-cycle acknowledge
    state_next.busy = !((avs_read || avs_write) && state_reg.busy);
    if (avs_read && state_reg.busy) begin
      state_next.rdata = efd_pkg::RST_RDATA;
      if (avs_address == efd_pkg::OFS_MODE_PKT) begin
        state_next.rdata[efd_pkg::PKT_ID_MSB:efd_pkg::PKT_ID_LSB] = efd_pkg::PKT_ID;
        state_next.rdata[efd_pkg::PKT_FRAG_DEC_BIT] = state_reg.frag_count_decrement;
        state_next.rdata[efd_pkg::PKT_FORCE_BIT] = state_reg.forced_wide_decode;
        state_next.rdata[efd_pkg::PKT_TAG_MSB:0] = state_reg.tag_count_decrement;
      end else if (avs_address == efd_pkg::OFS_STATUS) begin
        state_next.rdata[efd_pkg::ST_MODE_BIT] = state_reg.mode;
        state_next.rdata[efd_pkg::ST_FORCE_BIT] = state_reg.forced_wide_decode;
        state_next.rdata[efd_pkg::ST_FRAG_LSB +: 7] = ctr_val[efd_pkg::NUM_TAGS];
      end else if (avs_address == efd_pkg::OFS_TAG_EN) begin
        state_next.rdata[efd_pkg::PKT_TAG_MSB:0] = state_reg.tag_en;
      end else if (avs_address >= efd_pkg::OFS_TAG_CTR
                   && avs_address <= efd_pkg::OFS_TAG_CTR_END
                   && avs_address[1:0] == 2'b00) begin
        idx = avs_address[5:2];
        state_next.rdata[6:0] = ctr_val[idx];
      end
    end
    if (pkt_accept) begin
      state_next.frag_count_decrement = avs_writedata[efd_pkg::PKT_FRAG_DEC_BIT];
      state_next.forced_wide_decode = avs_writedata[efd_pkg::PKT_FORCE_BIT];
      state_next.tag_count_decrement = avs_writedata[efd_pkg::PKT_TAG_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.busy <= 1'b1;
      state_reg.rdata <= efd_pkg::RST_RDATA;
      state_reg.tag_count_decrement <= efd_pkg::RST_TAG_DEC;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata = state_reg.rdata;
  assign avs_waitrequest = state_reg.busy;
  assign every_frame_decode_mode = state_reg.mode;
  assign decode_frame = state_reg.decode;
  assign status_valid = state_reg.stat_valid;
  assign status_eof = state_reg.stat_eof;
  assign tag_enabled = state_reg.tag_en;

  ////////////////////////////////////////////////////////////////////////////
  mode_force_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && state_reg.forced_wide_decode) |=> every_frame_decode_mode)
    else $error("force bit did not hold the mode on");
  mode_idle_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !state_reg.forced_wide_decode && !any_busy) |=> !every_frame_decode_mode)
    else $error("mode stayed on with nothing pending");
  mode_busy_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && any_busy) |=> every_frame_decode_mode)
    else $error("mode off while counters pending");
  frame_decode_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && frame_start && every_frame_decode_mode) |=> decode_frame)
    else $error("frame skipped in every-frame mode");
  eof_report_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && frame_end && every_frame_decode_mode) |=> (status_valid && status_eof))
    else $error("no frame-end report in every-frame mode");
  tag_disable_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && ctr_val[0] == 7'h00) |=> !tag_enabled[0])
    else $error("tag still enabled at zero");
  bus_ack_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && avs_waitrequest && (avs_read || avs_write)) |=> !avs_waitrequest)
    else $error("no acknowledge after one wait cycle");
  pkt_hold_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !pkt_accept) |=> $stable(state_reg.forced_wide_decode))
    else $error("force bit changed without a packet");
endmodule

// >>> test/host_model.sv
module host_model (
  input wire logic clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end
  // one bus cycle, held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // mode packet on chosen byte lanes
  task automatic send_lanes(input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    avs_address <= efd_pkg::OFS_MODE_PKT;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= 1'b0;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_byteenable <= 4'hF;
  endtask
  // host-built mode packet, sent when data is over
  task automatic send_packet(input logic frag, input logic force_on, input logic [15:0] tags);
    logic [31:0] q;
    access(1'b1, efd_pkg::OFS_MODE_PKT, {efd_pkg::PKT_ID, frag, force_on, 6'h00, tags}, q);
  endtask
endmodule

// >>> test/every_frame_decode_control_bench.sv
module every_frame_decode_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, decoder_on = 1'b1, tag_assign_valid = 1'b0;
  logic [3:0] tag_assign_index = 4'h0;
  logic frag_vector_valid = 1'b0, frame_start = 1'b0, programmed_frame = 1'b0, frame_end = 1'b0;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, mode, decode_frame, status_valid, status_eof;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] tag_enabled;
  logic seen_dec, seen_st;
  int n_mismatch = 0;
  int checked = 0;
  every_frame_decode_control dut (.clk(clk), .reset(reset), .clk_en(1'b1),
    .decoder_on(decoder_on), .tag_assign_valid(tag_assign_valid),
    .tag_assign_index(tag_assign_index), .frag_vector_valid(frag_vector_valid),
    .frame_start(frame_start), .programmed_frame(programmed_frame), .frame_end(frame_end),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .every_frame_decode_mode(mode), .decode_frame(decode_frame),
    .status_valid(status_valid), .status_eof(status_eof), .tag_enabled(tag_enabled));
  host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    host.access(1'b0, a, 32'h00000000, q);
    chk(name, exp, q);
  endtask
  // event pulse: 0 tag, 1 fragment, 2 frame start, 3 frame end
  task automatic pulse(input int k, input logic [3:0] idx);
    @(posedge clk);
    tag_assign_index <= idx;
    case (k)
      0: tag_assign_valid <= 1'b1;
      1: frag_vector_valid <= 1'b1;
      2: frame_start <= 1'b1;
      default: frame_end <= 1'b1;
    endcase
    @(posedge clk);
    tag_assign_valid <= 1'b0;
    frag_vector_valid <= 1'b0;
    frame_start <= 1'b0;
    frame_end <= 1'b0;
    seen_dec = 1'b0;
    seen_st = 1'b0;
    repeat (3) begin
      @(negedge clk);
      seen_dec |= decode_frame;
      seen_st |= status_valid & status_eof;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(efd_pkg::OFS_MODE_PKT, 32'h03000000, "mode_pkt");
    rd(efd_pkg::OFS_STATUS, 32'h00000000, "status");
    chk("tag_enabled", 32'h00000000, {16'h0000, tag_enabled});
  endtask
  task automatic t_tags();
    pulse(0, 4'h5);
    pulse(0, 4'h5);
    rd(8'h54, 32'h00000002, "tag5_ctr");
    chk("tag_enabled", 32'h00000020, {16'h0000, tag_enabled});
    chk("mode", 32'h1, {31'h0, mode});
    host.send_packet(1'b0, 1'b0, 16'h0020);
    rd(8'h54, 32'h00000001, "tag5_ctr");
    chk("mode", 32'h1, {31'h0, mode});
    host.send_packet(1'b0, 1'b0, 16'h0020);
    rd(efd_pkg::OFS_TAG_EN, 32'h00000000, "tag_en_reg");
    chk("mode", 32'h0, {31'h0, mode});
    host.send_packet(1'b0, 1'b0, 16'h0020);
    rd(8'h54, 32'h00000000, "tag5_ctr");
  endtask
  task automatic t_frag();
    pulse(1, 4'h0);
    rd(efd_pkg::OFS_STATUS, 32'h00000101, "status");
    host.send_packet(1'b0, 1'b0, 16'h0000);
    rd(efd_pkg::OFS_STATUS, 32'h00000101, "status");
    fork
      host.send_packet(1'b1, 1'b0, 16'h0000);
      begin
        repeat (2) @(posedge clk);
        frag_vector_valid <= 1'b1;
        @(posedge clk);
        frag_vector_valid <= 1'b0;
      end
    join
    rd(efd_pkg::OFS_STATUS, 32'h00000101, "status");
    host.send_packet(1'b1, 1'b0, 16'h0000);
    rd(efd_pkg::OFS_STATUS, 32'h00000000, "status");
  endtask
  task automatic t_force();
    host.send_packet(1'b0, 1'b1, 16'h0000);
    rd(efd_pkg::OFS_STATUS, 32'h00000003, "status");
    pulse(2, 4'h0);
    chk("decode_any", 32'h1, {31'h0, seen_dec});
    pulse(3, 4'h0);
    chk("eof_report", 32'h1, {31'h0, seen_st});
    host.send_packet(1'b0, 1'b0, 16'h0000);
    pulse(2, 4'h0);
    chk("decode_any", 32'h0, {31'h0, seen_dec});
    pulse(3, 4'h0);
    chk("eof_report", 32'h0, {31'h0, seen_st});
    @(posedge clk);
    programmed_frame <= 1'b1;
    pulse(2, 4'h0);
    chk("decode_prog", 32'h1, {31'h0, seen_dec});
  endtask
  task automatic t_refuse_sat();
    logic [31:0] q;
    pulse(1, 4'h0);
    host.access(1'b1, efd_pkg::OFS_MODE_PKT, 32'h04800000, q);
    host.send_lanes(4'h7, 32'h03800000);
    host.access(1'b1, efd_pkg::OFS_STATUS, 32'h03800000, q);
    rd(efd_pkg::OFS_STATUS, 32'h00000101, "status");
    rd(8'h3C, 32'h00000000, "unmapped");
    repeat (130) pulse(1, 4'h0);
    rd(efd_pkg::OFS_STATUS, 32'h00007F01, "status");
    @(posedge clk);
    decoder_on <= 1'b0;
    repeat (2) @(posedge clk);
    decoder_on <= 1'b1;
    rd(efd_pkg::OFS_STATUS, 32'h00000000, "status");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_tags();
    t_frag();
    t_force();
    t_refuse_sat();
    print_verdict();
  end
endmodule
